// file: logic/rbf_pkg.sv
// shared constants, carriers and helpers of the radio bridge forwarding block
package rbf_pkg;

    // register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_IDLE = 8'h04;
    localparam logic [7:0] REG_TXDLY = 8'h08;
    localparam logic [7:0] REG_RPT = 8'h0c;
    localparam logic [7:0] REG_AIR = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    localparam logic [7:0] REG_DUP = 8'h18;
    localparam logic [7:0] REG_CRCERR = 8'h1c;

    // control register fields
    localparam int CTRL_RPT_BIT = 0;
    localparam int CTRL_STREAM_BIT = 1;
    localparam int CTRL_ID_LSB = 8;
    localparam int CTRL_ID_MSB = 15;
    localparam int RPT_MSB = 3;

    // reset values
    localparam logic [7:0] UNIT_ID_RST = 8'h01;
    localparam logic [15:0] IDLE_RST = 16'h0064;
    localparam logic [15:0] TXDLY_RST = 16'h0000;
    localparam logic [3:0] RPT_RST = 4'h0;
    localparam logic [15:0] AIR_RST = 16'h0008;

    // radio frame layout: origin, sequence, repeater count, payload, crc
    localparam int HDR_LEN = 3;
    localparam logic [1:0] HDR_ORG = 2'h0;
    localparam logic [1:0] HDR_SEQ = 2'h1;
    localparam logic [1:0] HDR_RPT = 2'h2;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [7:0] CRC_POLY = 8'h07;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } rbf_byte_t;

    typedef struct packed {
        logic valid;
        logic [47:0] src;
        logic [47:0] dst;
    } rbf_eth_hdr_t;

    typedef struct packed {
        logic valid;
        logic pass;
    } rbf_eth_fwd_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_HDR = 2'b01,
        TX_BODY = 2'b10,
        TX_CRC = 2'b11
    } rbf_tx_state_t;

    function automatic logic [7:0] rbf_crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : rbf_crc8

endpackage : rbf_pkg

// file: logic/rbf_top.sv
// radio bridge forwarding: serial framing, radio relay, duplicate filter, mac learning
`timescale 1ns/100ps

// Function
// - forward every accepted packet to matching interfaces
// - serial frame to radio, both remote ports
// - repeater retransmits every good, first-seen radio packet received while not busy with the previous one
// - never relay an already relayed packet; code relays any first-seen good packet
// - deliver a repeated packet only once
// - drop copies already delivered or self originated
// - idle gap between bytes closes serial frame
// - streaming starts radio send on first byte
// - user frames go out without extra queuing
// - no collision avoidance, overlaps are lost
// - crc on every packet, deliver only good
// - learn source macs as local or remote
// - radio only for non-local ethernet destinations
// - per-unit configurable transmit delay
// - own repeater count in every header
// - hold off after reception, buffer user data
// - repeater relays at once, no back-off
// - ethernet ip address plays no forwarding part
module rbf_top #(
    parameter int BUF_DEPTH = 64,
    parameter int HIST_DEPTH = 8,
    parameter int MAC_DEPTH = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata_q,
    input wire rbf_pkg::rbf_byte_t first_serial_port_rx,
    input wire rbf_pkg::rbf_byte_t second_serial_port_rx,
    output rbf_pkg::rbf_byte_t first_serial_port_tx_q,
    output rbf_pkg::rbf_byte_t second_serial_port_tx_q,
    input wire rbf_pkg::rbf_byte_t radio_rx,
    output rbf_pkg::rbf_byte_t radio_tx_q,
    input wire logic radio_tx_ready,
    input wire rbf_pkg::rbf_eth_hdr_t eth_local,
    input wire rbf_pkg::rbf_eth_hdr_t eth_remote,
    output rbf_pkg::rbf_eth_fwd_t eth_fwd_q
);
    localparam int AW = $clog2(BUF_DEPTH);
    localparam int HW = $clog2(HIST_DEPTH);
    localparam int MW = $clog2(MAC_DEPTH);
    localparam logic [AW:0] BUF_FULL = (AW + 1)'(BUF_DEPTH);

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic rpt_en_q;
    logic stream_q;
    logic [7:0] unit_id_q;
    logic [15:0] idle_q;
    logic [15:0] txdly_q;
    logic [3:0] rpt_q;
    logic [15:0] air_q;
    logic [15:0] dup_cnt_q;
    logic [15:0] crc_err_cnt_q;
    logic [31:0] hold_q;

    // own frame assembly
    logic [7:0] txbuf [BUF_DEPTH];
    logic own_active_q;
    logic own_closed_q;
    logic own_port_q;
    logic [AW:0] tx_wr_q;
    logic [15:0] gap_q;
    logic [15:0] dly_q;
    logic [7:0] seq_q;

    // radio reception
    logic [7:0] rxbuf [BUF_DEPTH];
    logic [8:0] rx_idx_q;
    logic [7:0] rx_crc_q;
    logic [7:0] rx_org_q;
    logic [7:0] rx_seq_q;
    logic [3:0] rx_rpt_q;
    logic rx_drop_q;
    logic [AW:0] rx_len_q;
    logic deliv_q;
    logic [AW:0] dptr_q;
    logic relay_pend_q;
    rbf_pkg::rbf_byte_t ser_tx_q;

    // packet history
    logic [15:0] hist_q [HIST_DEPTH];
    logic [HIST_DEPTH-1:0] hist_v_q;
    logic [HW-1:0] hist_wp_q;
    logic [HIST_DEPTH-1:0] hist_hit;

    // transmit engine
    rbf_pkg::rbf_tx_state_t tx_state_q;
    logic tx_relay_q;
    logic [1:0] hidx_q;
    logic [AW:0] tptr_q;
    logic [7:0] tcrc_q;
    logic [7:0] tx_org_q;
    logic [7:0] tx_seq_q;

    // mac table
    logic [47:0] mac_q [MAC_DEPTH];
    logic [MAC_DEPTH-1:0] mac_v_q;
    logic [MAC_DEPTH-1:0] mac_rem_q;
    logic [MW-1:0] mac_wp_q;

    ////////////////////////////////////////////////////////////////////////////////
    // register bus
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rpt_en_q <= 1'b0;
            stream_q <= 1'b0;
            unit_id_q <= rbf_pkg::UNIT_ID_RST;
            idle_q <= rbf_pkg::IDLE_RST;
            txdly_q <= rbf_pkg::TXDLY_RST;
            rpt_q <= rbf_pkg::RPT_RST;
            air_q <= rbf_pkg::AIR_RST;
        end else if (wr) begin
            case (addr)
                rbf_pkg::REG_CTRL: begin
                    rpt_en_q <= wdata[rbf_pkg::CTRL_RPT_BIT];
                    stream_q <= wdata[rbf_pkg::CTRL_STREAM_BIT];
                    unit_id_q <= wdata[rbf_pkg::CTRL_ID_MSB:rbf_pkg::CTRL_ID_LSB];
                end
                rbf_pkg::REG_IDLE: idle_q <= wdata[15:0];
                rbf_pkg::REG_TXDLY: txdly_q <= wdata[15:0];
                rbf_pkg::REG_RPT: rpt_q <= wdata[rbf_pkg::RPT_MSB:0];
                rbf_pkg::REG_AIR: air_q <= wdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else if (rd) begin
            case (addr)
                rbf_pkg::REG_CTRL: rdata_q <= {16'h0, unit_id_q, 6'h0, stream_q, rpt_en_q};
                rbf_pkg::REG_IDLE: rdata_q <= {16'h0, idle_q};
                rbf_pkg::REG_TXDLY: rdata_q <= {16'h0, txdly_q};
                rbf_pkg::REG_RPT: rdata_q <= {28'h0, rpt_q};
                rbf_pkg::REG_AIR: rdata_q <= {16'h0, air_q};
                rbf_pkg::REG_STAT: rdata_q <= {24'h0, (hold_q != 32'h0), tx_state_q,
                    relay_pend_q, deliv_q, own_closed_q, own_active_q, rpt_en_q};
                rbf_pkg::REG_DUP: rdata_q <= {16'h0, dup_cnt_q};
                rbf_pkg::REG_CRCERR: rdata_q <= {16'h0, crc_err_cnt_q};
                default: rdata_q <= 32'h0;
            endcase
        end else begin
            rdata_q <= 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial ingress and framing
    logic in_v;
    logic [7:0] in_d;
    logic own_ready;
    logic own_start;
    logic own_done;
    logic can_emit;
    logic rx_new;

    always_comb begin
        if (own_active_q) begin
            in_v = !own_closed_q && (own_port_q ? second_serial_port_rx.valid
                                                : first_serial_port_rx.valid);
            in_d = own_port_q ? second_serial_port_rx.data : first_serial_port_rx.data;
        end else begin
            // a new frame on both ports at once: the first port wins, the other is lost
            in_v = first_serial_port_rx.valid || second_serial_port_rx.valid;
            in_d = first_serial_port_rx.valid ? first_serial_port_rx.data
                                              : second_serial_port_rx.data;
        end
    end

    // once closed, the own frame waits for delay, hold-off and any relay pending or in progress
    assign own_ready = own_active_q && (own_closed_q || (stream_q && tx_wr_q != '0));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            own_active_q <= 1'b0;
            own_closed_q <= 1'b0;
            own_port_q <= 1'b0;
            tx_wr_q <= '0;
            gap_q <= 16'h0;
        end else if (own_done) begin
            own_active_q <= 1'b0;
            own_closed_q <= 1'b0;
            tx_wr_q <= '0;
            gap_q <= 16'h0;
        end else if (in_v) begin
            if (!own_active_q) begin
                own_port_q <= !first_serial_port_rx.valid;
            end
            own_active_q <= 1'b1;
            gap_q <= 16'h0;
            if (tx_wr_q != BUF_FULL) begin
                tx_wr_q <= tx_wr_q + 1'b1;
            end
        end else if (own_active_q && !own_closed_q) begin
            if (gap_q >= idle_q) begin
                own_closed_q <= 1'b1;
            end else begin
                gap_q <= gap_q + 16'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (in_v && tx_wr_q != BUF_FULL) begin
            txbuf[tx_wr_q[AW-1:0]] <= in_d;
        end
    end

    // stagger timer, runs once the own frame may leave
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dly_q <= 16'h0;
        end else if (!own_ready) begin
            dly_q <= 16'h0;
        end else if (dly_q < txdly_q) begin
            dly_q <= dly_q + 16'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            seq_q <= 8'h0;
        end else if (own_start) begin
            seq_q <= seq_q + 8'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // radio reception, crc and duplicate filter
    logic [7:0] rx_crc_next;
    logic rx_done;
    logic rx_good;
    logic rx_dup;
    logic rx_busy;
    logic [AW:0] rx_pay;
    logic [31:0] air_prod;

    assign rx_crc_next = rbf_pkg::rbf_crc8((rx_idx_q == 9'h0) ? rbf_pkg::CRC_INIT : rx_crc_q,
                                           radio_rx.data);
    assign rx_done = radio_rx.valid && radio_rx.last;
    assign rx_pay = (AW + 1)'(rx_idx_q - 9'(rbf_pkg::HDR_LEN));
    // residue zero over data plus crc byte, and whole payload held
    assign rx_good = rx_done && rx_crc_next == 8'h0 && rx_idx_q >= 9'(rbf_pkg::HDR_LEN)
                     && rx_idx_q <= 9'(rbf_pkg::HDR_LEN + BUF_DEPTH);

    genvar gi;
    generate
        for (gi = 0; gi < HIST_DEPTH; gi++) begin : g_hist
            assign hist_hit[gi] = hist_v_q[gi] && hist_q[gi] == {rx_org_q, rx_seq_q};
        end
    endgenerate

    assign rx_dup = (|hist_hit) || rx_org_q == unit_id_q;
    assign rx_new = rx_good && !rx_dup && !rx_drop_q;
    assign rx_busy = deliv_q || relay_pend_q || (tx_state_q != rbf_pkg::TX_IDLE && tx_relay_q);
    assign air_prod = 32'(air_q) * (32'(rx_idx_q) + 32'h1) * 32'(rx_rpt_q);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_idx_q <= 9'h0;
            rx_crc_q <= rbf_pkg::CRC_INIT;
            rx_org_q <= 8'h0;
            rx_seq_q <= 8'h0;
            rx_rpt_q <= 4'h0;
            rx_drop_q <= 1'b0;
            rx_len_q <= '0;
        end else if (radio_rx.valid) begin
            rx_crc_q <= rx_crc_next;
            rx_idx_q <= radio_rx.last ? 9'h0 : rx_idx_q + 9'h1;
            // a frame arriving while the previous one is still in use is lost
            if (rx_idx_q == 9'h0) begin
                rx_drop_q <= rx_busy;
            end
            if (rx_idx_q == 9'(rbf_pkg::HDR_ORG)) begin
                rx_org_q <= radio_rx.data;
            end
            if (rx_idx_q == 9'(rbf_pkg::HDR_SEQ)) begin
                rx_seq_q <= radio_rx.data;
            end
            if (rx_idx_q == 9'(rbf_pkg::HDR_RPT)) begin
                rx_rpt_q <= radio_rx.data[rbf_pkg::RPT_MSB:0];
            end
            if (rx_new) begin
                rx_len_q <= rx_pay;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (radio_rx.valid && !rx_busy && rx_idx_q >= 9'(rbf_pkg::HDR_LEN)
            && rx_pay < BUF_FULL) begin
            rxbuf[rx_pay[AW-1:0]] <= radio_rx.data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dup_cnt_q <= 16'h0;
            crc_err_cnt_q <= 16'h0;
        end else begin
            if (rx_good && rx_dup) begin
                dup_cnt_q <= dup_cnt_q + 16'h1;
            end
            if (rx_done && !rx_good) begin
                crc_err_cnt_q <= crc_err_cnt_q + 16'h1;
            end
        end
    end

    // every good frame reserves air for its repeats; no carrier sense otherwise
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hold_q <= 32'h0;
        end else if (rx_good) begin
            hold_q <= air_prod;
        end else if (hold_q != 32'h0) begin
            hold_q <= hold_q - 32'h1;
        end
    end

    // history: own frames and first-seen radio frames; own start never meets rx_new
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hist_v_q <= '0;
            hist_wp_q <= '0;
        end else if (rx_new || own_start) begin
            hist_v_q[hist_wp_q] <= 1'b1;
            hist_wp_q <= (hist_wp_q == HW'(HIST_DEPTH - 1)) ? '0 : hist_wp_q + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rx_new) begin
            hist_q[hist_wp_q] <= {rx_org_q, rx_seq_q};
        end else if (own_start) begin
            hist_q[hist_wp_q] <= {unit_id_q, seq_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // delivery of first-seen payload to both serial ports
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            deliv_q <= 1'b0;
            dptr_q <= '0;
            ser_tx_q <= '0;
        end else if (rx_new) begin
            deliv_q <= rx_pay != '0;
            dptr_q <= '0;
            ser_tx_q <= '0;
        end else if (deliv_q) begin
            ser_tx_q.valid <= 1'b1;
            ser_tx_q.data <= rxbuf[dptr_q[AW-1:0]];
            ser_tx_q.last <= dptr_q == rx_len_q - 1'b1;
            dptr_q <= dptr_q + 1'b1;
            if (dptr_q == rx_len_q - 1'b1) begin
                deliv_q <= 1'b0;
            end
        end else begin
            ser_tx_q <= '0;
        end
    end

    // same stream on both ports; own frames never loop back locally
    assign first_serial_port_tx_q = ser_tx_q;
    assign second_serial_port_tx_q = ser_tx_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            relay_pend_q <= 1'b0;
        end else if (rx_new) begin
            relay_pend_q <= rpt_en_q;
        end else if (tx_state_q == rbf_pkg::TX_IDLE && can_emit) begin
            relay_pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // radio transmit engine
    logic [7:0] hdr_byte;

    assign can_emit = !radio_tx_q.valid || radio_tx_ready;
    assign own_start = can_emit && tx_state_q == rbf_pkg::TX_IDLE && !relay_pend_q
                       && own_ready && dly_q >= txdly_q && hold_q == 32'h0 && !rx_new;
    assign own_done = can_emit && tx_state_q == rbf_pkg::TX_CRC && !tx_relay_q;

    always_comb begin
        case (hidx_q)
            rbf_pkg::HDR_ORG: hdr_byte = tx_org_q;
            rbf_pkg::HDR_SEQ: hdr_byte = tx_seq_q;
            default: hdr_byte = {4'h0, rpt_q};
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_state_q <= rbf_pkg::TX_IDLE;
            tx_relay_q <= 1'b0;
            hidx_q <= 2'h0;
            tptr_q <= '0;
            tcrc_q <= rbf_pkg::CRC_INIT;
            tx_org_q <= 8'h0;
            tx_seq_q <= 8'h0;
            radio_tx_q <= '0;
        end else if (can_emit) begin
            radio_tx_q <= '0;
            case (tx_state_q)
                rbf_pkg::TX_IDLE: begin
                    hidx_q <= 2'h0;
                    tptr_q <= '0;
                    tcrc_q <= rbf_pkg::CRC_INIT;
                    if (relay_pend_q) begin
                        // straight after reception, hold-off not applied
                        tx_relay_q <= 1'b1;
                        tx_org_q <= rx_org_q;
                        tx_seq_q <= rx_seq_q;
                        tx_state_q <= rbf_pkg::TX_HDR;
                    end else if (own_start) begin
                        tx_relay_q <= 1'b0;
                        tx_org_q <= unit_id_q;
                        tx_seq_q <= seq_q;
                        tx_state_q <= rbf_pkg::TX_HDR;
                    end
                end
                rbf_pkg::TX_HDR: begin
                    radio_tx_q <= '{valid: 1'b1, data: hdr_byte, last: 1'b0};
                    tcrc_q <= rbf_pkg::rbf_crc8(tcrc_q, hdr_byte);
                    hidx_q <= hidx_q + 2'h1;
                    if (hidx_q == rbf_pkg::HDR_RPT) begin
                        tx_state_q <= rbf_pkg::TX_BODY;
                    end
                end
                rbf_pkg::TX_BODY: begin
                    if (tx_relay_q) begin
                        if (tptr_q == rx_len_q) begin
                            tx_state_q <= rbf_pkg::TX_CRC;
                        end else begin
                            radio_tx_q <= '{valid: 1'b1, data: rxbuf[tptr_q[AW-1:0]],
                                            last: 1'b0};
                            tcrc_q <= rbf_pkg::rbf_crc8(tcrc_q, rxbuf[tptr_q[AW-1:0]]);
                            tptr_q <= tptr_q + 1'b1;
                        end
                    end else if (tptr_q != tx_wr_q) begin
                        // streaming reads right behind the serial writer
                        radio_tx_q <= '{valid: 1'b1, data: txbuf[tptr_q[AW-1:0]], last: 1'b0};
                        tcrc_q <= rbf_pkg::rbf_crc8(tcrc_q, txbuf[tptr_q[AW-1:0]]);
                        tptr_q <= tptr_q + 1'b1;
                    end else if (own_closed_q) begin
                        tx_state_q <= rbf_pkg::TX_CRC;
                    end
                end
                rbf_pkg::TX_CRC: begin
                    radio_tx_q <= '{valid: 1'b1, data: tcrc_q, last: 1'b1};
                    tx_state_q <= rbf_pkg::TX_IDLE;
                end
                default: tx_state_q <= rbf_pkg::TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ethernet mac learning filter; forwarding looks at macs only, never ip
    logic [MAC_DEPTH-1:0] loc_hit;
    logic [MAC_DEPTH-1:0] rem_hit;
    logic [MAC_DEPTH-1:0] dst_hit;
    logic [MW-1:0] loc_idx;
    logic [MW-1:0] rem_idx;
    logic dst_local;

    generate
        for (gi = 0; gi < MAC_DEPTH; gi++) begin : g_mac
            assign loc_hit[gi] = mac_v_q[gi] && mac_q[gi] == eth_local.src;
            assign rem_hit[gi] = mac_v_q[gi] && mac_q[gi] == eth_remote.src;
            assign dst_hit[gi] = mac_v_q[gi] && mac_q[gi] == eth_local.dst && !mac_rem_q[gi];
        end
    endgenerate

    always_comb begin
        loc_idx = mac_wp_q;
        rem_idx = mac_wp_q;
        for (int i = MAC_DEPTH - 1; i >= 0; i--) begin
            if (loc_hit[i]) begin
                loc_idx = MW'(i);
            end
            if (rem_hit[i]) begin
                rem_idx = MW'(i);
            end
        end
        dst_local = |dst_hit;
    end

    // local learning wins when both sides report in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mac_v_q <= '0;
            mac_rem_q <= '0;
            mac_wp_q <= '0;
        end else if (eth_local.valid) begin
            mac_v_q[loc_idx] <= 1'b1;
            mac_rem_q[loc_idx] <= 1'b0;
            if (!(|loc_hit)) begin
                mac_wp_q <= mac_wp_q + 1'b1;
            end
        end else if (eth_remote.valid) begin
            mac_v_q[rem_idx] <= 1'b1;
            mac_rem_q[rem_idx] <= 1'b1;
            if (!(|rem_hit)) begin
                mac_wp_q <= mac_wp_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (eth_local.valid) begin
            mac_q[loc_idx] <= eth_local.src;
        end else if (eth_remote.valid) begin
            mac_q[rem_idx] <= eth_remote.src;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            eth_fwd_q <= '0;
        end else begin
            eth_fwd_q.valid <= eth_local.valid;
            eth_fwd_q.pass <= eth_local.valid && !dst_local;
        end
    end

endmodule : rbf_top

// file: tb/rbf_radio_model.sv
// radio modem model: takes outgoing radio bytes, stalls one cycle in four
`timescale 1ns/100ps
module rbf_radio_model (
    input wire logic clock,
    input wire rbf_pkg::rbf_byte_t tx,
    output logic ready
);
    logic [7:0] q[$];
    logic [1:0] cnt = 2'h0;
    always @(posedge clock) begin
        cnt <= cnt + 2'h1;
        if (tx.valid && ready) q.push_back(tx.data);
    end
    // periodic stall so the sender must hold its byte
    assign ready = cnt != 2'h3;
endmodule : rbf_radio_model

// file: tb/rbf_properties.sv
// port checks of the radio bridge forwarding block
`timescale 1ns/100ps
module rbf_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic rd,
    input wire logic [31:0] rdata_q,
    input wire rbf_pkg::rbf_byte_t first_serial_port_tx_q,
    input wire rbf_pkg::rbf_byte_t second_serial_port_tx_q,
    input wire rbf_pkg::rbf_byte_t radio_rx,
    input wire rbf_pkg::rbf_byte_t radio_tx_q,
    input wire logic radio_tx_ready,
    input wire rbf_pkg::rbf_eth_hdr_t eth_local,
    input wire rbf_pkg::rbf_eth_fwd_t eth_fwd_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_stall;
        radio_tx_q.valid && !radio_tx_ready;
    endsequence
    property p_rdz; !rd |=> rdata_q == 32'h0; endproperty
    property p_eth_v; eth_local.valid |=> eth_fwd_q.valid; endproperty
    property p_eth_n; !eth_local.valid |=> !eth_fwd_q.valid; endproperty
    property p_ser_eq; first_serial_port_tx_q == second_serial_port_tx_q; endproperty
    property p_ser_last; first_serial_port_tx_q.last |-> first_serial_port_tx_q.valid; endproperty
    property p_tx_hold; s_stall |=> $stable(radio_tx_q); endproperty
    property p_tx_last; radio_tx_q.last |-> radio_tx_q.valid; endproperty
    // delivery only opens two cycles after a closing radio byte
    property p_deliv;
        $rose(first_serial_port_tx_q.valid) |-> $past(radio_rx.valid && radio_rx.last, 2);
    endproperty
    a_rdz: assert property (p_rdz) else $error("read data not cleared");
    a_eth_v: assert property (p_eth_v) else $error("no filter answer");
    a_eth_n: assert property (p_eth_n) else $error("stray filter answer");
    a_ser_eq: assert property (p_ser_eq) else $error("serial ports differ");
    a_ser_last: assert property (p_ser_last) else $error("last without valid");
    a_tx_hold: assert property (p_tx_hold) else $error("radio byte dropped");
    a_tx_last: assert property (p_tx_last) else $error("radio last idle");
    a_deliv: assert property (p_deliv) else $error("delivery without frame");
endmodule : rbf_chk
bind rbf_top rbf_chk u_chk (.clock, .rst, .rd, .rdata_q, .first_serial_port_tx_q,
    .second_serial_port_tx_q, .radio_rx, .radio_tx_q, .radio_tx_ready, .eth_local, .eth_fwd_q);

// file: tb/rbf_top_tb.sv
// self-checking bench of the radio bridge forwarding block
`timescale 1ns/100ps
module rbf_top_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata_q;
    logic rdy;
    rbf_pkg::rbf_byte_t s1 = '0, s2 = '0, rrx = '0, t1, t2, rtx;
    rbf_pkg::rbf_eth_hdr_t el = '0, er = '0;
    rbf_pkg::rbf_eth_fwd_t ef;
    logic [7:0] sq[$];
    logic [31:0] rv[9] = '{32'h100, 32'h64, 32'h0, 32'h0, 32'h8, 32'h0, 32'h0, 32'h0, 32'h0};
    int err_count = 0;
    int samples_checked = 0;
    always #5 clock = ~clock;
    rbf_top DUT (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata_q,
        .first_serial_port_rx(s1), .second_serial_port_rx(s2), .first_serial_port_tx_q(t1),
        .second_serial_port_tx_q(t2), .radio_rx(rrx), .radio_tx_q(rtx), .radio_tx_ready(rdy),
        .eth_local(el), .eth_remote(er), .eth_fwd_q(ef));
    rbf_radio_model modem (.clock(clock), .tx(rtx), .ready(rdy));
    always @(posedge clock) if (t1.valid) sq.push_back(t1.data);
    task end_sim;
        if (err_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 r = rdata_q;
    endtask : acc
    function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
        return x;
    endfunction : crc
    task rsend(input logic [7:0] org, input logic [7:0] pay, input logic bad);
        logic [7:0] b[5];
        b = '{org, 8'h05, 8'h00, pay, 8'h00};
        for (int i = 0; i < 4; i++) b[4] = crc(b[4], b[i]);
        b[4] = b[4] ^ {7'h0, bad};
        for (int i = 0; i < 5; i++) begin
            @(posedge clock);
            rrx <= '{1'b1, b[i], i == 4};
        end
        @(posedge clock);
        rrx <= '0;
        repeat (40) @(posedge clock);
    endtask : rsend
    initial begin
        logic [31:0] r;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            acc(1'b0, 8'(i * 4), 32'h0, r);
            chk(r, rv[i]);
        end
        acc(1'b1, rbf_pkg::REG_IDLE, 32'h4, r);
        acc(1'b1, rbf_pkg::REG_RPT, 32'h3, r);
        acc(1'b1, rbf_pkg::REG_DUP, 32'h5, r);
        @(posedge clock);
        s1 <= '{1'b1, 8'ha5, 1'b0};
        @(posedge clock);
        s1 <= '0;
        for (int i = 0; i < 300 && modem.q.size() < 5; i++) @(posedge clock);
        chk(modem.q[0], 32'h1);
        chk(modem.q[2], 32'h3);
        chk(modem.q[3], 32'ha5);
        chk(modem.q[4], crc(crc(crc(crc(8'h0, 8'h01), 8'h00), 8'h03), 8'ha5));
        chk(sq.size(), 32'h0);
        rsend(8'h02, 8'h3c, 1'b0);
        rsend(8'h02, 8'h3c, 1'b0);
        acc(1'b0, rbf_pkg::REG_DUP, 32'h0, r);
        chk(r, 32'h1);
        rsend(8'h03, 8'h77, 1'b1);
        acc(1'b0, rbf_pkg::REG_CRCERR, 32'h0, r);
        chk(r, 32'h1);
        rsend(8'h01, 8'h66, 1'b0);
        chk(sq.size(), 32'h1);
        chk(sq[0], 32'h3c);
        acc(1'b1, rbf_pkg::REG_CTRL, 32'h101, r);
        rsend(8'h04, 8'h5a, 1'b0);
        rsend(8'h04, 8'h5a, 1'b0);
        chk(modem.q.size(), 32'ha);
        chk(modem.q[8], 32'h5a);
        @(posedge clock);
        el <= '{1'b1, 48'h1, 48'h2};
        @(posedge clock);
        el <= '{1'b1, 48'h2, 48'h1};
        #1 chk(ef.pass, 32'h1);
        @(posedge clock);
        el <= '0;
        er <= '{1'b1, 48'h1, 48'h0};
        #1 chk(ef.pass, 32'h0);
        @(posedge clock);
        er <= '0;
        el <= '{1'b1, 48'h2, 48'h1};
        @(posedge clock);
        el <= '0;
        #1 chk(ef.pass, 32'h1);
        end_sim;
    end
    initial begin
        #200000;
        err_count++;
        end_sim;
    end
endmodule : rbf_top_tb
